// ==== agc_loop.sv ====
/*
   Log-domain automatic gain control loop for one complex receive channel,
   with its Wishbone register slave.
   Assumes samples arrive synchronous to clk_i with a one-cycle valid strobe.
*/
// Behaviour
// - Log2 of averaged power, halved for rms
// - Error is request level minus rms
// - Request level 0 to -23.99 dB
// - Target: 2-bit exponent, 6-bit mantissa
// - Second-order loop filter, poles 1 and P
// - Small error uses small gain, else large
// - Gains and pole are code over 256
// - Threshold: 4-bit exponent, 8-bit mantissa
// - Gain is two raised to filter output
// - 8-bit multiply then coarse 4-bit shift
// - Initial gain applied before loop runs
// - 19-bit scaled products feed power measure
// - Truncate output to selected word length
// - Mode bit one selects clipping tracking
// - Clipping mode measures truncation residue
// - Clipping mode subtracts same target level
// - Mode bit zero measures I^2 + Q^2
// - First-order CIC, ratio 1 to 4096
// - Pre-CIC right shift 0 to 14
module agc_loop
   import agc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic in_valid_i,
   input wire logic signed [IN_W-1:0] in_inph_i,
   input wire logic signed [IN_W-1:0] in_quad_i,
   output logic out_valid_o,
   output logic [OUT_W-1:0] out_inph_o,
   output logic [OUT_W-1:0] out_quad_o,
   output logic [GAIN_W-1:0] out_gain_o
);
   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_lanes

   // Bits dropped below the kept word: widths 4,5,6,7,8,10,12,16.
   function automatic logic [SC_W-1:0] low_mask(input logic [2:0] code);
      logic [4:0] drop;
      case (code)
         3'h0: drop = 5'h0f;
         3'h1: drop = 5'h0e;
         3'h2: drop = 5'h0d;
         3'h3: drop = 5'h0c;
         3'h4: drop = 5'h0b;
         3'h5: drop = 5'h09;
         3'h6: drop = 5'h07;
         default: drop = 5'h03;
      endcase
      return (SC_W'(1) << drop) - SC_W'(1);
   endfunction : low_mask

   // Integer part is the leading-one position, fraction the next 8 bits.
   function automatic logic [LOG_W-1:0] log2_fix(input logic [ACC_W-1:0] v);
      logic [5:0] msb;
      logic [ACC_W-1:0] norm;
      msb = 6'h00;
      for (int i = 0; i < ACC_W; i++) begin
         if (v[i]) begin
            msb = 6'(i);
         end
      end
      norm = v << (6'(ACC_W - 1) - msb);
      return {msb, norm[ACC_W-2 -: FRAC_W]};
   endfunction : log2_fix

   function automatic logic signed [SC_W-1:0] sat_sc(input logic signed [46:0] v);
      if (v > 47'sd262143) begin
         return 19'sh3ffff;
      end else if (v < -47'sd262144) begin
         return 19'sh40000;
      end
      return v[SC_W-1:0];
   endfunction : sat_sc

   // ----------------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------------
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [31:0] rd_mux;
   logic [31:0] wdata;
   logic wr_en;
   logic [4:0] ctrl_ff;
   logic [7:0] target_ff;
   logic [7:0] k_small_ff;
   logic [7:0] k_large_ff;
   logic [7:0] pole_ff;
   logic [11:0] thresh_ff;
   logic [11:0] init_gain_ff;
   logic [11:0] ratio_ff;
   logic [1:0] navg_ff;
   logic [3:0] scale_ff;
   agc_loop_state_type state_ff;
   logic signed [Y_W-1:0] y_ff;
   logic signed [ERR_W-1:0] e_prev_ff;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (adr_i)
         ADDR_CTRL: rd_mux = {27'h0, ctrl_ff};
         ADDR_TARGET: rd_mux = {24'h0, target_ff};
         ADDR_K_SMALL: rd_mux = {24'h0, k_small_ff};
         ADDR_K_LARGE: rd_mux = {24'h0, k_large_ff};
         ADDR_POLE: rd_mux = {24'h0, pole_ff};
         ADDR_THRESH: rd_mux = {20'h0, thresh_ff};
         ADDR_INIT_GAIN: rd_mux = {20'h0, init_gain_ff};
         ADDR_AVERAGE: rd_mux = {12'h0, scale_ff, 2'h0, navg_ff, ratio_ff};
         ADDR_GAIN_STAT: rd_mux = {15'h0, state_ff == LS_RUN, 4'h0, out_gain_o};
         ADDR_ERR_STAT: rd_mux = {{16{e_prev_ff[ERR_W-1]}}, e_prev_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   assign wdata = merge_lanes(rd_mux, dat_i, sel_i);
   // A write lands on the edge at which the master sees ack high.
   assign wr_en = cyc_i & stb_i & we_i & ack_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= cyc_i & stb_i & ~ack_ff;
         if (cyc_i & stb_i & ~ack_ff) begin
            dat_ff <= rd_mux;
         end
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RST;
         target_ff <= TARGET_RST;
         k_small_ff <= K_SMALL_RST;
         k_large_ff <= K_LARGE_RST;
         pole_ff <= POLE_RST;
         thresh_ff <= THRESH_RST;
         init_gain_ff <= INIT_GAIN_RST;
         ratio_ff <= RATIO_RST;
         navg_ff <= NAVG_RST;
         scale_ff <= SCALE_RST;
      end else if (wr_en) begin
         case (adr_i)
            ADDR_CTRL: ctrl_ff <= wdata[4:0];
            ADDR_TARGET: target_ff <= wdata[7:0];
            ADDR_K_SMALL: k_small_ff <= wdata[7:0];
            ADDR_K_LARGE: k_large_ff <= wdata[7:0];
            ADDR_POLE: pole_ff <= wdata[7:0];
            ADDR_THRESH: thresh_ff <= wdata[11:0];
            ADDR_INIT_GAIN: init_gain_ff <= wdata[11:0];
            ADDR_AVERAGE: begin
               ratio_ff <= wdata[11:0];
               navg_ff <= wdata[AVG_NAVG_LSB +: 2];
               // Codes above the largest shift are held at it.
               scale_ff <= (wdata[AVG_SCALE_LSB +: 4] > SCALE_MAX) ? SCALE_MAX :
                           wdata[AVG_SCALE_LSB +: 4];
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Gain multiplier and truncation
   // ----------------------------------------------------------------------
   logic clip_mode;
   logic v1_ff;
   logic v2_ff;
   logic [SC_W-1:0] mask;
   logic signed [IN_W-1:0] in_arr [2];
   logic signed [SC_W-1:0] scaled_ff [2];
   logic signed [SC_W-1:0] meas_ff [2];
   logic [OUT_W-1:0] out_ff [2];
   logic [36:0] sq [2];

   assign clip_mode = ctrl_ff[CTRL_CLIP_BIT];
   assign mask = low_mask(ctrl_ff[CTRL_WLEN_LSB +: 3]);
   assign in_arr[0] = in_inph_i;
   assign in_arr[1] = in_quad_i;

   generate
      for (genvar c = 0; c < 2; c++) begin : g_chan
         logic signed [31:0] fine;
         logic signed [46:0] coarse;
         logic signed [SC_W-1:0] trunc;
         logic signed [37:0] sqs;
         // Mantissa with its hidden one, then shifted by the exponent.
         assign fine = in_arr[c] * $signed({2'b01, out_gain_o[7:0]});
         assign coarse = (47'(fine) <<< out_gain_o[11:8]) >>> 11;
         assign trunc = scaled_ff[c] & ~$signed(mask);
         assign sqs = meas_ff[c] * meas_ff[c];
         assign sq[c] = sqs[36:0];

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               scaled_ff[c] <= '0;
               meas_ff[c] <= '0;
               out_ff[c] <= '0;
            end else begin
               if (in_valid_i) begin
                  scaled_ff[c] <= sat_sc(coarse);
               end
               if (v1_ff) begin
                  out_ff[c] <= trunc[SC_W-1 -: OUT_W];
                  // The residue below the kept word is what clipping mode tracks.
                  meas_ff[c] <= clip_mode ? (scaled_ff[c] & $signed(mask)) :
                                scaled_ff[c];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         v1_ff <= 1'b0;
         v2_ff <= 1'b0;
      end else begin
         v1_ff <= in_valid_i;
         v2_ff <= v1_ff;
      end
   end

   assign out_valid_o = v2_ff;
   assign out_inph_o = out_ff[0];
   assign out_quad_o = out_ff[1];

   // ----------------------------------------------------------------------
   // Power, scaling and average-and-decimate
   // ----------------------------------------------------------------------
   logic [37:0] pwr_sum;
   logic [ACC_W-1:0] pwr;
   logic [ACC_W-1:0] acc_ff;
   logic [11:0] cnt_ff;
   logic [ACC_W-1:0] blk_ff [NBLK];
   logic [ACC_W-1:0] avg;
   logic dump_ff;
   logic run;

   assign run = (state_ff == LS_RUN);
   assign pwr_sum = {1'b0, sq[0]} + {1'b0, sq[1]};
   assign pwr = ACC_W'(pwr_sum) >> scale_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         acc_ff <= '0;
         cnt_ff <= 12'h000;
         dump_ff <= 1'b0;
         for (int k = 0; k < NBLK; k++) begin
            blk_ff[k] <= '0;
         end
      end else begin
         dump_ff <= 1'b0;
         if (v2_ff) begin
            if (cnt_ff == ratio_ff) begin
               acc_ff <= '0;
               cnt_ff <= 12'h000;
               blk_ff[0] <= acc_ff + pwr;
               for (int k = 1; k < NBLK; k++) begin
                  blk_ff[k] <= blk_ff[k-1];
               end
               dump_ff <= 1'b1;
            end else begin
               acc_ff <= acc_ff + pwr;
               cnt_ff <= cnt_ff + 12'h001;
            end
         end
      end
   end

   // The average spans 1 to 4 of the most recent block sums.
   always_comb begin
      avg = '0;
      for (int k = 0; k < NBLK; k++) begin
         if (2'(k) <= navg_ff) begin
            avg = avg + blk_ff[k];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Error and loop filter
   // ----------------------------------------------------------------------
   logic [LOG_W-1:0] pwr_log;
   logic signed [ERR_W-1:0] rms;
   logic signed [ERR_W-1:0] target_log;
   logic signed [ERR_W-1:0] err;
   logic [ERR_W-1:0] err_abs;
   logic [7:0] k_sel;
   logic signed [V_W-1:0] v_ff;
   logic signed [V_W-1:0] nxt_v;
   logic signed [V_W-1:0] y_sum;
   logic signed [36:0] pole_term;
   logic signed [24:0] gain_term;

   assign pwr_log = log2_fix(avg);
   assign rms = $signed({3'b000, pwr_log[LOG_W-1:1]});
   // Exponent worth 256 steps, mantissa worth 4 steps of 1/256 octave.
   assign target_log = $signed({6'h00, target_ff, 2'b00});
   // Request level is FS minus target; error is request minus rms.
   assign err = FS_LOG - target_log - rms;
   assign err_abs = e_prev_ff[ERR_W-1] ? ERR_W'(-e_prev_ff) : e_prev_ff;
   assign k_sel = (err_abs < {4'h0, thresh_ff}) ? k_small_ff : k_large_ff;
   // y[n] = y[n-1] + P*(y[n-1]-y[n-2]) + K*e[n-1], held in v as the step.
   assign pole_term = $signed({1'b0, pole_ff}) * v_ff;
   assign gain_term = $signed({1'b0, k_sel}) * e_prev_ff;
   assign nxt_v = V_W'(pole_term >>> FRAC_W) + V_W'(gain_term);
   assign y_sum = V_W'(y_ff) + nxt_v;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= LS_INIT;
      end else begin
         case (state_ff)
            LS_INIT: if (ctrl_ff[CTRL_EN_BIT]) state_ff <= LS_RUN;
            LS_RUN: if (!ctrl_ff[CTRL_EN_BIT]) state_ff <= LS_INIT;
            default: state_ff <= LS_INIT;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         y_ff <= Y_W'({init_gain_ff, 8'h00});
         v_ff <= '0;
         e_prev_ff <= '0;
      end else if (dump_ff) begin
         e_prev_ff <= err;
         // Clearing the step at a rail keeps it from winding up.
         if (y_sum < 0) begin
            y_ff <= '0;
            v_ff <= '0;
         end else if (y_sum > V_W'(Y_MAX)) begin
            y_ff <= Y_MAX;
            v_ff <= '0;
         end else begin
            y_ff <= y_sum[Y_W-1:0];
            v_ff <= nxt_v;
         end
      end
   end

   assign out_gain_o = y_ff[FRAC_W +: GAIN_W];
endmodule : agc_loop

// ==== agc_loop_assertions.sv ====
/*
   Checker for the gain control loop, bound to the ports of agc_loop.
   Assumes one clock and the synchronous active-high reset of the block.
*/
module agc_loop_assertions
   import agc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic in_valid_i,
   input wire logic signed [IN_W-1:0] in_inph_i,
   input wire logic signed [IN_W-1:0] in_quad_i,
   input wire logic out_valid_o,
   input wire logic [OUT_W-1:0] out_inph_o,
   input wire logic [OUT_W-1:0] out_quad_o,
   input wire logic [GAIN_W-1:0] out_gain_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------------
   // Ages of the last sample and the last register write
   // ----------------------------------------------------------------------
   // The gain may only move a few cycles after one of these two causes.
   logic [3:0] since_in_ff;
   logic [3:0] since_wr_ff;
   always_ff @(posedge clk_i) begin
      since_in_ff <= (rst_i || in_valid_i) ? 4'h0 : since_in_ff + {3'h0, since_in_ff != 4'hf};
   end
   always_ff @(posedge clk_i) begin
      since_wr_ff <= (rst_i || (ack_o && we_i)) ? 4'h0 : since_wr_ff + {3'h0, since_wr_ff != 4'hf};
   end
   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not acknowledged in the next cycle");
   a_ack_single_pulse: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   a_no_spurious_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("acknowledge without a request");
   a_read_data_held: assert property (!ack_o |-> $stable(dat_o))
      else $error("read data changed without an acknowledge");
   a_unmapped_reads_zero: assert property (cyc_i && stb_i && !ack_o && !we_i && adr_i == 8'h30
      |=> dat_o == 32'h0)
      else $error("unmapped address read nonzero");
   a_sample_latency: assert property (in_valid_i |-> ##2 out_valid_o)
      else $error("scaled sample missing two cycles after input");
   a_valid_has_cause: assert property (out_valid_o |-> $past(in_valid_i, 2))
      else $error("output strobe without an input sample");
   a_output_holds: assert property (!out_valid_o |-> $stable(out_inph_o) && $stable(out_quad_o))
      else $error("output word changed without a strobe");
   a_gain_moves_on_update: assert property (!$stable(out_gain_o)
      |-> since_in_ff < 4'h9 || since_wr_ff < 4'h5)
      else $error("gain changed away from any block update");
   c_back_to_back: cover property (in_valid_i ##1 in_valid_i);
   c_gain_moved: cover property (!$stable(out_gain_o));
   c_read_done: cover property (ack_o && !we_i);
endmodule : agc_loop_assertions

bind agc_loop agc_loop_assertions i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
   .sel_i, .dat_o, .ack_o, .in_valid_i, .in_inph_i, .in_quad_i, .out_valid_o, .out_inph_o,
   .out_quad_o, .out_gain_o);

// ==== agc_pkg.sv ====
/*
   Constants, register map and types for the log-domain gain control loop.
   Assumes a single 40 MHz clock and a classic Wishbone slave with 32-bit data.
*/
package agc_pkg;
   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int IN_W = 22;
   localparam int SC_W = 19;
   localparam int OUT_W = 16;
   localparam int GAIN_W = 12;
   localparam int LOG_W = 14;
   localparam int ACC_W = 52;
   localparam int ERR_W = 16;
   localparam int FRAC_W = 8;
   localparam int Y_W = 24;
   localparam int V_W = 28;
   localparam int NBLK = 4;
   // ----------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TARGET = 8'h04;
   localparam logic [7:0] ADDR_K_SMALL = 8'h08;
   localparam logic [7:0] ADDR_K_LARGE = 8'h0c;
   localparam logic [7:0] ADDR_POLE = 8'h10;
   localparam logic [7:0] ADDR_THRESH = 8'h14;
   localparam logic [7:0] ADDR_INIT_GAIN = 8'h18;
   localparam logic [7:0] ADDR_AVERAGE = 8'h1c;
   localparam logic [7:0] ADDR_GAIN_STAT = 8'h20;
   localparam logic [7:0] ADDR_ERR_STAT = 8'h24;
   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CLIP_BIT = 1;
   localparam int CTRL_WLEN_LSB = 2;
   localparam int AVG_NAVG_LSB = 12;
   localparam int AVG_SCALE_LSB = 16;
   localparam int STAT_RUN_BIT = 16;
   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [7:0] TARGET_RST = 8'h00;
   localparam logic [7:0] K_SMALL_RST = 8'h00;
   localparam logic [7:0] K_LARGE_RST = 8'h00;
   localparam logic [7:0] POLE_RST = 8'h00;
   localparam logic [11:0] THRESH_RST = 12'h000;
   localparam logic [11:0] INIT_GAIN_RST = 12'h000;
   localparam logic [11:0] RATIO_RST = 12'h000;
   localparam logic [1:0] NAVG_RST = 2'h0;
   localparam logic [3:0] SCALE_RST = 4'h0;
   // ----------------------------------------------------------------------
   // Loop constants
   // ----------------------------------------------------------------------
   localparam logic [3:0] SCALE_MAX = 4'he;
   // Full-scale amplitude of a 19-bit sample, log2 in 1/256 steps (18 * 256).
   localparam logic signed [ERR_W-1:0] FS_LOG = 16'sh1200;
   localparam logic [Y_W-1:0] Y_MAX = 24'h0fffff;
   typedef enum logic {LS_INIT, LS_RUN} agc_loop_state_type;
endpackage : agc_pkg

// ==== agc_src_model.sv ====
/*
   Upstream sample source standing in for the data router.
   Assumes send is entered just after a rising clock edge.
*/
module agc_src_model
   import agc_pkg::*;
(
   input wire logic clk_i,
   output logic in_valid_o,
   output logic signed [IN_W-1:0] in_inph_o,
   output logic signed [IN_W-1:0] in_quad_o
);
   initial begin
      in_valid_o = 1'b0;
      in_inph_o = '0;
      in_quad_o = '0;
   end
   // With a nonzero gap the lines carry the inverse word with valid low; with gap 0 valid stays high on the last word.
   task send(input logic signed [IN_W-1:0] i, input logic signed [IN_W-1:0] q, input int gap);
      in_valid_o <= 1'b1;
      in_inph_o <= i;
      in_quad_o <= q;
      @(posedge clk_i);
      if (gap > 0) begin
         in_valid_o <= 1'b0;
         in_inph_o <= ~i;
         in_quad_o <= ~q;
         repeat (gap) @(posedge clk_i);
      end
   endtask : send
endmodule : agc_src_model

// ==== tb_agc_loop.sv ====
/*
   Self-checking bench for agc_loop: registers, scaling, truncation, loop.
   Assumes the checker is bound to the design and samples come from agc_src_model.
*/
module tb_agc_loop import agc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_o;
   logic ack_o, in_valid_i, out_valid_o;
   logic signed [IN_W-1:0] in_inph_i, in_quad_i;
   logic [OUT_W-1:0] out_inph_o, out_quad_o;
   logic [GAIN_W-1:0] out_gain_o;
   int fail_count = 0, n_checks = 0, cyc_cnt = 0;
   logic [31:0] rd_q[$], sm_q[$];
   bit track = 1'b0;
   logic [11:0] cur_g = 12'h0;
   logic [2:0] cur_wl = 3'h0;
   int wt[8] = '{4, 5, 6, 7, 8, 10, 12, 16};
   logic [7:0] ra[8] = '{ADDR_CTRL, ADDR_TARGET, ADDR_K_SMALL, ADDR_K_LARGE, ADDR_POLE,
      ADDR_THRESH, ADDR_INIT_GAIN, ADDR_AVERAGE};
   logic [31:0] rm[8] = '{32'h1f, 32'hff, 32'hff, 32'hff, 32'hff, 32'hfff, 32'hfff, 32'hf3fff};

   always #12.5 clk_i = ~clk_i;

   agc_src_model i_src (.clk_i(clk_i), .in_valid_o(in_valid_i), .in_inph_o(in_inph_i),
      .in_quad_o(in_quad_i));
   agc_loop i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o,
      .ack_o, .in_valid_i, .in_inph_i, .in_quad_i, .out_valid_o, .out_inph_o, .out_quad_o,
      .out_gain_o);
   // ----------------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------------
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   // Model of the scaler and the truncation, with the gain the bench programmed.
   function automatic logic [15:0] exp_out(input logic signed [IN_W-1:0] x);
      logic signed [63:0] p;
      p = x;
      p = (p * (256 + int'(cur_g[7:0]))) <<< cur_g[11:8];
      p = p >>> 11;
      if (p > 64'sh3ffff) p = 64'sh3ffff;
      if (p < -64'sh40000) p = -64'sh40000;
      return p[18:3] & (16'hffff << (16 - wt[cur_wl]));
   endfunction : exp_out
   always @(posedge clk_i) begin
      if (!rst_i && ack_o === 1'b1 && !we_i) begin
         if (rd_q.size() == 0) chk("spare read", 32'h1, 32'h0);
         else chk("register read", dat_o, rd_q.pop_front());
      end
      if (track && out_valid_o === 1'b1) begin
         if (sm_q.size() == 0) chk("spare sample", 32'h1, 32'h0);
         else chk("scaled sample", {out_inph_o, out_quad_o}, sm_q.pop_front());
      end
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------------
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      chk("bus wait", n, 32'd2);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hf);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   task smp(input int gap);
      logic signed [IN_W-1:0] i, q;
      i = $signed(IN_W'($urandom)) >>> ($urandom % 16);
      q = $signed(IN_W'($urandom)) >>> ($urandom % 16);
      sm_q.push_back({exp_out(i), exp_out(q)});
      i_src.send(i, q, gap);
   endtask : smp
   // Gain starts from 0x800; a half-scale constant input saturates the scaler.
   task loop_run(input logic [31:0] ctl, input logic [31:0] th, input logic [31:0] ks,
      input logic [31:0] kl, input int n);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_THRESH, th);
      wr(ADDR_K_SMALL, ks);
      wr(ADDR_K_LARGE, kl);
      wr(ADDR_CTRL, ctl);
      repeat (n) i_src.send(22'sh100000, 22'sh100000, 3);
      repeat (12) @(posedge clk_i);
   endtask : loop_run
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      logic [31:0] d, e;
      void'($urandom(32'h456b));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ra[k]) rd(ra[k], 32'h0);
      rd(ADDR_GAIN_STAT, 32'h0);
      wr(ADDR_ERR_STAT, 32'hffffffff);
      rd(ADDR_ERR_STAT, 32'h0);
      wr(8'h30, $urandom);
      rd(8'h30, 32'h0);
      foreach (ra[k]) begin
         d = $urandom;
         e = d & rm[k];
         if (k == 7 && e[19:16] == 4'hf) e[19:16] = 4'he;
         wr(ra[k], d);
         rd(ra[k], e);
      end
      wr(ADDR_AVERAGE, 32'h000f0000);
      rd(ADDR_AVERAGE, 32'h000e0000);
      wr(ADDR_THRESH, 32'h0);
      wb(1'b1, ADDR_THRESH, 32'hfff, 4'h1);
      rd(ADDR_THRESH, 32'h0ff);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_AVERAGE, 32'h0);
      // Unity averaging with no shift needs no scaler offset in the request level.
      wr(ADDR_TARGET, 32'h0);
      wr(ADDR_POLE, 32'h0);
      track = 1'b1;
      for (int wl = 0; wl < 8; wl++) begin
         cur_g = 12'($urandom);
         cur_wl = 3'(wl);
         wr(ADDR_INIT_GAIN, {20'h0, cur_g});
         wr(ADDR_CTRL, {27'h0, cur_wl, cur_wl[0], 1'b0});
         chk("initial gain", {20'h0, out_gain_o}, {20'h0, cur_g});
         for (int j = 0; j < 4; j++) smp(j == 3 ? 2 : 0);
      end
      repeat (4) @(posedge clk_i);
      track = 1'b0;
      chk("samples left", sm_q.size(), 32'h0);
      wr(ADDR_INIT_GAIN, 32'h800);
      loop_run(32'h1, 32'h0, 32'h0, 32'h80, 8);
      chk("gain falls", {31'h0, out_gain_o < 12'h800}, 32'h1);
      loop_run(32'h1, 32'hfff, 32'h80, 32'h0, 8);
      chk("small error gain", {31'h0, out_gain_o < 12'h800}, 32'h1);
      loop_run(32'h1, 32'h0, 32'h80, 32'h0, 8);
      chk("large error gain", {20'h0, out_gain_o}, 32'h800);
      rd(ADDR_ERR_STAT, 32'hffff_ff81);
      loop_run(32'h3, 32'h0, 32'h0, 32'hff, 16);
      chk("clip tracking", {20'h0, out_gain_o}, 32'hfff);
      rd(ADDR_GAIN_STAT, 32'h0001_0fff);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADDR_CTRL, 32'h0);
      chk("gain after reset", {20'h0, out_gain_o}, 32'h0);
      tally_and_finish();
   end
endmodule : tb_agc_loop
